// ==== include/dmr_pkg.sv ====
// Purpose: Shared constants and types of the readout register set block
// Assumes: 200 MHz core clock, command clock sampled as a plain input
// Notes: Latencies and tMOD are counted in command clock cycles
package dmr_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CORE_CLK_MHZ = 200;
	localparam int unsigned TEMP_AGE_MS = 32;
	localparam int unsigned TEMP_UPD_CYC = TEMP_AGE_MS * CORE_CLK_MHZ * 1000;
	localparam logic [7:0] TMOD_CK = 8'h18;
	localparam int unsigned SYNC_STAGES = 2;

	// ----------------------------------------
	// Mode register numbers and field positions
	// ----------------------------------------
	localparam logic [2:0] MR_BURST = 3'h0;
	localparam logic [2:0] MR_READOUT = 3'h3;
	localparam logic [2:0] MR_PREAMBLE = 3'h4;
	localparam logic [2:0] MR_PARITY = 3'h5;
	localparam int unsigned MR3_EN_BIT = 2;
	localparam int unsigned MR3_TEMP_BIT = 5;
	localparam int unsigned MR3_FMT_LSB = 11;
	localparam int unsigned MR4_RDPRE_BIT = 11;
	localparam int unsigned A_CHOP_BIT = 12;
	localparam int unsigned A_ORDER_BIT = 2;
	localparam int unsigned TEMP_LSB = 3;

	// ----------------------------------------
	// Encodings and values after reset
	// ----------------------------------------
	localparam logic [1:0] FMT_SERIAL = 2'h0;
	localparam logic [1:0] FMT_PARALLEL = 2'h1;
	localparam logic [1:0] FMT_STAGGER = 2'h2;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] RST_PAGE = 2'h0;
	localparam logic [1:0] RST_FMT = 2'h0;
	localparam logic [1:0] RST_BL = 2'h0;
	localparam logic [2:0] RST_PAR_LAT = 3'h0;
	localparam logic [1:0] RST_TEMP = 2'h1;
	localparam logic [7:0] PAT_LOC0 = 8'h55;
	localparam logic [7:0] PAT_LOC1 = 8'h33;
	localparam logic [7:0] PAT_LOC2 = 8'h0f;
	localparam logic [7:0] PAT_LOC3 = 8'h00;
	localparam logic [7:0] RESERVED_VALUE = 8'h00;
	localparam logic [7:0] LOC2_DONTCARE_MASK = 8'hfd;
	localparam int unsigned SLOT_BITS = 6;
	localparam int unsigned SLOTS = 64;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic mrs;
		logic rd;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [17:0] addr;
	} dmr_cmd_s;

	typedef struct packed {
		logic valid;
		logic chop;
		logic order;
		logic [7:0] word;
	} dmr_slot_s;

endpackage : dmr_pkg

// ==== core/dmr_sync.sv ====
// Purpose: Two flip-flop synchroniser for pins from another clock domain
// Assumes: Bits of the bus are stable around the sampling point
// Notes: Only the second stage may be read
`timescale 1ns/1ps
module dmr_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule : dmr_sync

// ==== core/dmr_readout.sv ====
// Purpose: Readout register set mode of a DRAM: mode entry, reads, bursts
// Assumes: Command pins are decoded strobes held across the command clock rise
// Notes: Two data beats per command clock, on its rising and falling edge
`timescale 1ns/1ps

// Overview of operation
// RULE1: Temperature status refreshed while enable bit set
// RULE2: Temperature status never older than 32 ms
// RULE3: Temperature status frozen while enable bit clear
// RULE4: Error log readable only after mode entry
// RULE5: Controller ignores unused logged address bit
// RULE6: Location 3 low bits show parity latency
// RULE7: Strobes driven with data, preamble honoured
// RULE8: Page 0 reads may use short spacing
// RULE9: Pages 1-3 reads need long spacing
// RULE10: Controller locks DLL, precharges, waits tRP
// RULE11: Entry write sets enable, format, page
// RULE12: Controller waits tMRD and tMOD before reads
// RULE13: Reads return location chosen by bank bits
// RULE14: Fixed length 8 or chop 4 only
// RULE15: Controller sets chop bit high on OTF
// RULE16: Address bit 2 selects burst order
// RULE17: Controller drives address bits 1:0 zero
// RULE18: Other address inputs are ignored
// RULE19: Burst starts read latency after read
// RULE20: Controller waits exit recovery before exit
// RULE21: Exit write clears enable; ready after tMOD
// RULE22: Serial format: same pattern every lane
// RULE23: Parallel format: first beat repeats, location 0
// RULE24: Reserved page returns fixed zeros
module dmr_readout #(
	parameter int unsigned TEMP_UPD_CYC = dmr_pkg::TEMP_UPD_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_ck,
	input wire logic i_cmd_mrs,
	input wire logic i_cmd_rd,
	input wire logic [1:0] i_bg,
	input wire logic [1:0] i_ba,
	input wire logic [17:0] i_addr,
	input wire logic [5:0] i_cas_latency,
	input wire logic [5:0] i_add_latency,
	input wire logic [1:0] i_temp_rate,
	input wire logic [25:0] i_ca_err_log,
	input wire logic [31:0] i_mr_readout,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	output logic o_dqs,
	output logic o_dqs_oe,
	output logic o_mode_active,
	output logic [1:0] o_page,
	output logic [1:0] o_format,
	output logic [1:0] o_temp_status,
	output logic o_core_ready,
	output logic o_illegal_rd
);
	typedef struct packed {
		logic ck_prev;
		logic mode_en;
		logic [1:0] page;
		logic [1:0] fmt;
		logic temp_en;
		logic [1:0] bl_mode;
		logic [2:0] par_lat;
		logic rd_pre2;
		logic [1:0] temp_stat;
		logic [22:0] temp_cnt;
		logic [5:0] ck_cnt;
		dmr_pkg::dmr_slot_s [dmr_pkg::SLOTS-1:0] slots;
		logic busy;
		logic [2:0] beat;
		dmr_pkg::dmr_slot_s cur;
		logic [7:0] tmod_cnt;
		logic core_ready;
		logic [7:0] dq;
		logic dq_oe;
		logic dqs;
		logic dqs_oe;
		logic illegal;
	} dmr_state_s;

	dmr_state_s st_q;
	dmr_state_s st_d;
	dmr_pkg::dmr_cmd_s cmd_raw;
	dmr_pkg::dmr_cmd_s cmd_s;
	logic ck_s;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	assign cmd_raw = '{mrs: i_cmd_mrs, rd: i_cmd_rd, bg: i_bg, ba: i_ba, addr: i_addr};

	dmr_sync #(.W(1)) u_ck_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_async(i_ck),
		.o_sync(ck_s)
	);

	dmr_sync #(.W($bits(dmr_pkg::dmr_cmd_s))) u_cmd_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_async(cmd_raw),
		.o_sync(cmd_s)
	);

	// ----------------------------------------
	// Location contents
	// ----------------------------------------
	function automatic logic [7:0] loc_word(input logic [1:0] page, input logic [1:0] loc,
			input logic [1:0] temp, input logic [2:0] par_lat);
		logic [7:0] w;
		w = dmr_pkg::RESERVED_VALUE; // [RULE24]
		unique case (page)
			2'h0: begin
				unique case (loc)
					2'h0: w = dmr_pkg::PAT_LOC0;
					2'h1: w = dmr_pkg::PAT_LOC1;
					2'h2: w = dmr_pkg::PAT_LOC2;
					2'h3: w = dmr_pkg::PAT_LOC3;
				endcase
			end
			2'h1: begin
				unique case (loc)
					2'h0: w = i_ca_err_log[7:0];
					2'h1: w = i_ca_err_log[15:8];
					2'h2: w = i_ca_err_log[23:16] & dmr_pkg::LOC2_DONTCARE_MASK; // [RULE5]
					2'h3: w = {i_ca_err_log[25:24], 3'h0, par_lat}; // [RULE6]
				endcase
			end
			2'h2: begin
				unique case (loc)
					2'h0: w = {i_mr_readout[7:5], temp, i_mr_readout[2:0]};
					2'h1: w = i_mr_readout[15:8];
					2'h2: w = i_mr_readout[23:16];
					2'h3: w = i_mr_readout[31:24];
				endcase
			end
			2'h3: w = dmr_pkg::RESERVED_VALUE; // [RULE24]
		endcase
		return w;
	endfunction : loc_word

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic rise;
		logic fall;
		logic [6:0] rl;
		logic [5:0] idx;
		logic [1:0] loc;
		logic [2:0] mr;
		logic [2:0] ui;
		logic pre;
		dmr_pkg::dmr_slot_s now;
		rise = 1'b0;
		fall = 1'b0;
		rl = 7'h0;
		idx = 6'h0;
		loc = 2'h0;
		mr = 3'h0;
		ui = 3'h0;
		pre = 1'b0;
		now = '0;
		st_d = st_q;
		rise = ck_s & ~st_q.ck_prev;
		fall = ~ck_s & st_q.ck_prev;
		st_d.ck_prev = ck_s;
		st_d.illegal = 1'b0;

		// Temperature sensor status sampling
		if (st_q.temp_en) begin // [RULE1]
			if (st_q.temp_cnt == 23'h0) begin
				st_d.temp_stat = i_temp_rate; // [RULE1]
				st_d.temp_cnt = 23'(TEMP_UPD_CYC - 1); // [RULE2]
			end else begin
				st_d.temp_cnt = st_q.temp_cnt - 23'h1;
			end
		end else begin
			st_d.temp_cnt = 23'h0; // [RULE3]
		end

		if (rise) begin
			// Mode register writes; bank group bit 0 and bank bits pick the register
			mr = {cmd_s.bg[0], cmd_s.ba};
			if (cmd_s.mrs) begin
				unique case (mr)
					dmr_pkg::MR_BURST: st_d.bl_mode = cmd_s.addr[1:0];
					dmr_pkg::MR_READOUT: begin
						st_d.mode_en = cmd_s.addr[dmr_pkg::MR3_EN_BIT]; // [RULE11] [RULE21]
						st_d.page = cmd_s.addr[1:0]; // [RULE11]
						st_d.fmt = cmd_s.addr[dmr_pkg::MR3_FMT_LSB+:2]; // [RULE11]
						st_d.temp_en = cmd_s.addr[dmr_pkg::MR3_TEMP_BIT]; // [RULE1] [RULE3]
						st_d.core_ready = 1'b0;
						st_d.tmod_cnt = dmr_pkg::TMOD_CK; // [RULE21]
					end
					dmr_pkg::MR_PREAMBLE: st_d.rd_pre2 = cmd_s.addr[dmr_pkg::MR4_RDPRE_BIT];
					dmr_pkg::MR_PARITY: st_d.par_lat = cmd_s.addr[2:0]; // [RULE6]
					default: begin
					end
				endcase
			end else if (st_q.tmod_cnt != 8'h0) begin
				st_d.tmod_cnt = st_q.tmod_cnt - 8'h1;
				st_d.core_ready = (st_q.tmod_cnt == 8'h1) && !st_q.mode_en; // [RULE21]
			end

			// Readout read: only bank bits, chop bit and address bit 2 are used
			if (cmd_s.rd && st_q.mode_en) begin // [RULE4] [RULE13] [RULE18]
				loc = cmd_s.ba; // [RULE13]
				if (st_q.fmt == dmr_pkg::FMT_PARALLEL && loc != 2'h0) begin
					st_d.illegal = 1'b1; // [RULE23]
					loc = 2'h0; // [RULE23]
				end
				rl = 7'(i_add_latency) + 7'(i_cas_latency); // [RULE19]
				idx = st_q.ck_cnt + rl[5:0]; // [RULE19]
				st_d.slots[idx].valid = 1'b1;
				st_d.slots[idx].order = cmd_s.addr[dmr_pkg::A_ORDER_BIT]; // [RULE16]
				st_d.slots[idx].chop = (st_q.bl_mode == dmr_pkg::BL_FIXED4) ||
					(st_q.bl_mode == dmr_pkg::BL_OTF && !cmd_s.addr[dmr_pkg::A_CHOP_BIT]); // [RULE14]
				st_d.slots[idx].word = loc_word(st_q.page, loc, st_q.temp_stat, st_q.par_lat);
			end

			now = st_q.slots[st_q.ck_cnt];
			st_d.slots[st_q.ck_cnt].valid = 1'b0;
			st_d.ck_cnt = st_q.ck_cnt + 6'h1;
		end

		// Burst sequencing, one beat per command clock edge
		if (rise || fall) begin
			if (now.valid) begin // [RULE19]
				st_d.busy = 1'b1;
				st_d.beat = 3'h0;
				st_d.cur = now;
			end else if (st_q.busy && st_q.beat != 3'h7) begin
				st_d.beat = st_q.beat + 3'h1;
			end else begin
				st_d.busy = 1'b0;
			end
			if (rise) begin
				pre = st_q.slots[6'(st_q.ck_cnt + 6'h1)].valid |
					(st_q.rd_pre2 & st_q.slots[6'(st_q.ck_cnt + 6'h2)].valid);
			end else begin
				pre = st_q.slots[st_q.ck_cnt].valid |
					(st_q.rd_pre2 & st_q.slots[6'(st_q.ck_cnt + 6'h1)].valid);
			end
			ui = st_d.beat ^ {st_d.cur.order, 2'h0}; // [RULE16]
			if (st_d.busy) begin
				if (st_d.fmt == dmr_pkg::FMT_PARALLEL) begin
					st_d.dq = {<<{st_d.cur.word}}; // [RULE23]
				end else begin
					st_d.dq = {8{st_d.cur.word[3'h7 - ui]}}; // [RULE22]
				end
				st_d.dq_oe = !(st_d.cur.chop && st_d.beat[2]); // [RULE14]
				st_d.dqs_oe = st_d.dq_oe; // [RULE7]
				st_d.dqs = ~st_d.beat[0]; // [RULE7]
			end else begin
				st_d.dq = 8'h00;
				st_d.dq_oe = 1'b0;
				st_d.dqs = 1'b0;
				st_d.dqs_oe = pre; // [RULE7]
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '0;
			st_q.page <= dmr_pkg::RST_PAGE;
			st_q.fmt <= dmr_pkg::RST_FMT;
			st_q.bl_mode <= dmr_pkg::RST_BL;
			st_q.par_lat <= dmr_pkg::RST_PAR_LAT;
			st_q.temp_stat <= dmr_pkg::RST_TEMP;
			st_q.core_ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_dq = st_q.dq;
	assign o_dq_oe = st_q.dq_oe;
	assign o_dqs = st_q.dqs;
	assign o_dqs_oe = st_q.dqs_oe;
	assign o_mode_active = st_q.mode_en;
	assign o_page = st_q.page;
	assign o_format = st_q.fmt;
	assign o_temp_status = st_q.temp_stat;
	assign o_core_ready = st_q.core_ready;
	assign o_illegal_rd = st_q.illegal;
endmodule : dmr_readout

// ==== bench/dmr_readout_asserts.sv ====
// Purpose: Port-level checks of the readout register set block
// Assumes: One core clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module dmr_readout_asserts (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [1:0] i_temp_rate,
	input wire logic [7:0] o_dq,
	input wire logic o_dq_oe,
	input wire logic o_dqs_oe,
	input wire logic o_mode_active,
	input wire logic [1:0] o_format,
	input wire logic [1:0] o_temp_status,
	input wire logic o_core_ready,
	input wire logic o_illegal_rd
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	a_strobe_with_dq: assert property (o_dq_oe |-> o_dqs_oe) else $error("data without strobe");
	a_data_in_mode: assert property (o_dq_oe |-> o_mode_active) else $error("data outside mode");
	a_serial_lanes: assert property (o_dq_oe && o_format != dmr_pkg::FMT_PARALLEL |-> o_dq inside {8'h00, 8'hff})
		else $error("lanes differ");
	a_beat_holds: assert property ($changed(o_dq) && o_dq_oe |=> (!o_dq_oe || $stable(o_dq))[*8])
		else $error("beat too short");
	a_temp_source: assert property ($changed(o_temp_status) |-> o_temp_status == $past(i_temp_rate))
		else $error("temperature not from sensor");
	a_busy_in_mode: assert property (o_mode_active |-> !o_core_ready) else $error("ready in mode");
	a_exit_waits: assert property ($fell(o_mode_active) |-> !o_core_ready [*8]) else $error("ready too early");
	a_illegal_cause: assert property (o_illegal_rd |-> o_mode_active && o_format == dmr_pkg::FMT_PARALLEL)
		else $error("bad illegal flag");
	a_illegal_pulse: assert property (o_illegal_rd |=> !o_illegal_rd) else $error("illegal flag too long");
endmodule : dmr_readout_asserts

bind dmr_readout dmr_readout_asserts u_asserts (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
	.i_temp_rate(i_temp_rate), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs_oe(o_dqs_oe),
	.o_mode_active(o_mode_active), .o_format(o_format), .o_temp_status(o_temp_status),
	.o_core_ready(o_core_ready), .o_illegal_rd(o_illegal_rd));

// ==== bench/dmr_ctrl_model.sv ====
// Purpose: Memory controller model issuing commands on the command clock
// Assumes: Free running command clock, 125 ns period
// Notes: Released bank and address pins show the inverse of their last value, strobes low
`timescale 1ns/1ps
module dmr_ctrl_model (
	input wire logic i_core_clk,
	output logic o_ck,
	output dmr_pkg::dmr_cmd_s o_cmd
);
	realtime t_rise;
	initial begin
		o_ck = 1'b0;
		o_cmd = '0;
		#1;
		forever #62.5 o_ck = ~o_ck;
	end
	// Held from fall to fall so the command straddles one rise; one command per clock at most
	task automatic send(input dmr_pkg::dmr_cmd_s c);
		@(negedge o_ck);
		@(posedge i_core_clk);
		o_cmd <= c;
		@(posedge o_ck);
		t_rise = $realtime;
		@(negedge o_ck);
		@(posedge i_core_clk);
		o_cmd <= '{mrs: 1'b0, rd: 1'b0, bg: ~c.bg, ba: ~c.ba, addr: ~c.addr};
	endtask : send
endmodule : dmr_ctrl_model

// ==== bench/test_dmr_readout.sv ====
// Purpose: Self-checking bench of the readout register set block
// Assumes: AL 2 and CL 6, so bursts start 8 command clocks after a read
// Notes: Temperature refresh period shortened to 50 core cycles
`timescale 1ns/1ps
module test_dmr_readout;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] trate = 2'h1;
	logic [25:0] elog = '0;
	logic [31:0] mrv = '0;
	logic [7:0] dq;
	logic dq_oe, dqs, dqs_oe, act, rdy, ill, ck;
	logic [1:0] page, fmt, temp, tsel;
	logic [2:0] par;
	logic [7:0] ex [4];
	logic [7:0] pat [4] = '{dmr_pkg::PAT_LOC0, dmr_pkg::PAT_LOC1, dmr_pkg::PAT_LOC2, dmr_pkg::PAT_LOC3};
	dmr_pkg::dmr_cmd_s cmd;
	int n_errors = 0, samples_checked = 0, cyc = 0, n_oe = 0, n_ill = 0, i, seed = 32'h7201, tpre = 1;
	always #2.5 clk = ~clk;
	dmr_ctrl_model u_ctl (.i_core_clk(clk), .o_ck(ck), .o_cmd(cmd));
	dmr_readout #(.TEMP_UPD_CYC(50)) DUT (.i_core_clk(clk), .i_rstn(rstn), .i_ck(ck), .i_cmd_mrs(cmd.mrs),
		.i_cmd_rd(cmd.rd), .i_bg(cmd.bg), .i_ba(cmd.ba), .i_addr(cmd.addr), .i_cas_latency(6'h06),
		.i_add_latency(6'h02), .i_temp_rate(trate), .i_ca_err_log(elog), .i_mr_readout(mrv), .o_dq(dq),
		.o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe), .o_mode_active(act), .o_page(page), .o_format(fmt),
		.o_temp_status(temp), .o_core_ready(rdy), .o_illegal_rd(ill));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		n_oe <= n_oe + int'(dq_oe === 1'b1);
		n_ill <= n_ill + int'(ill === 1'b1);
		if (cyc == 40000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic mrs(input logic [2:0] n, input logic [17:0] a, input int wait_ck);
		u_ctl.send('{mrs: 1'b1, rd: 1'b0, bg: {1'b0, n[2]}, ba: n[1:0], addr: a});
		repeat (wait_ck) @(posedge ck);
	endtask : mrs
	task automatic idle_rd();
		int k0;
		k0 = n_oe;
		u_ctl.send('{mrs: 1'b0, rd: 1'b1, bg: 2'h0, ba: 2'h1, addr: 18'h0});
		repeat (12) @(posedge ck);
		chk("idle oe", 8'(n_oe - k0), 8'h00);
	endtask : idle_rd
	// ----------------------------------------
	// Read and compare a burst against the expected beats
	// ----------------------------------------
	task automatic rd(input logic [1:0] loc, input logic a2, input logic [7:0] w, input logic chop, input logic prl);
		logic [31:0] r;
		realtime dt;
		int k;
		int np;
		logic [7:0] e;
		r = $random(seed);
		u_ctl.send('{mrs: 1'b0, rd: 1'b1, bg: r[19:18], ba: loc, addr: {r[17:13], 1'b1, r[11:3], a2, 2'b00}});
		np = 0;
		// Core cycles of strobe preamble before the first beat: one command clock is 25 of them
		for (k = 0; k < 1000 && dq_oe !== 1'b1; k++) begin
			np += int'(dqs_oe === 1'b1);
			@(posedge clk);
		end
		dt = $realtime - u_ctl.t_rise;
		chk("latency", 8'(dt > 1005.0 && dt < 1035.0), 8'h01);
		chk("preamble", 8'(np > 22 * tpre && np < 28 * tpre), 8'h01);
		#27;
		for (k = 0; k < 9; k++) begin
			if (prl)
				e = {<<{w}};
			else
				e = {8{w[7 - ((k + (a2 ? 4 : 0)) % 8)]}};
			chk("dq_oe", 8'(dq_oe), 8'(k < 8 && !(chop && k > 3)));
			chk("dqs_oe", 8'(dqs_oe), 8'(k < 8 && !(chop && k > 3)));
			if (k < 8 && !(chop && k > 3)) chk("dq", dq, e);
			if (k < 8 && !(chop && k > 3)) chk("dqs", 8'(dqs), 8'(k % 2 == 0));
			#62.5;
		end
	endtask : rd
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("reset outs", {dq_oe, dqs_oe, act, rdy, ill, temp, 1'b0}, 8'h12);
		idle_rd();
		@(posedge clk);
		elog <= 26'($random(seed));
		mrv <= $random(seed);
		tsel = $random(seed) & 1 ? 2'h2 : 2'h0;
		trate <= tsel;
		par = 3'($random(seed));
		mrs(3'h5, {15'h0, par}, 8);
		mrs(3'h3, 18'h24, 25);
		chk("mode", {act, rdy, page, fmt, 2'b00}, 8'h80);
		for (i = 0; i < 8; i++) rd(i[1:0], i[2], pat[i[1:0]], 1'b0, 1'b0);
		mrs(3'h4, 18'h0800, 8);
		tpre = 2;
		rd(2'h2, 1'b1, pat[2], 1'b0, 1'b0);
		mrs(3'h4, 18'h0, 8);
		tpre = 1;
		mrs(3'h0, {16'h0, dmr_pkg::BL_FIXED4}, 8);
		rd(2'h1, 1'b1, pat[1], 1'b1, 1'b0);
		mrs(3'h0, {16'h0, dmr_pkg::BL_OTF}, 8);
		rd(2'h2, 1'b1, pat[2], 1'b0, 1'b0);
		mrs(3'h0, 18'h0, 8);
		$display("test page 0 done");
		mrs(3'h3, 18'h25, 25);
		ex = '{elog[7:0], elog[15:8], elog[23:16] & 8'hfd, {elog[25:24], 3'h0, par}};
		for (i = 0; i < 4; i++) rd(i[1:0], 1'b0, ex[i], 1'b0, 1'b0);
		mrs(3'h3, 18'h26, 25);
		chk("page", {page, fmt, 4'h0}, 8'h80);
		ex = '{{mrv[7:5], tsel, mrv[2:0]}, mrv[15:8], mrv[23:16], mrv[31:24]};
		for (i = 0; i < 4; i++) rd(i[1:0], 1'b0, ex[i], 1'b0, 1'b0);
		chk("temp", 8'(temp), 8'(tsel));
		mrs(3'h3, 18'h06, 25);
		@(posedge clk);
		trate <= ~tsel;
		repeat (20) @(posedge ck);
		rd(2'h0, 1'b0, ex[0], 1'b0, 1'b0);
		mrs(3'h3, 18'h07, 25);
		rd(2'h1, 1'b0, dmr_pkg::RESERVED_VALUE, 1'b0, 1'b0);
		$display("test pages 1 and 2 done");
		mrs(3'h3, 18'h0804, 25);
		chk("format", {6'h0, fmt}, {6'h0, dmr_pkg::FMT_PARALLEL});
		i = n_ill;
		rd(2'h2, 1'b0, pat[0], 1'b0, 1'b1);
		chk("illegal rd", 8'(n_ill - i), 8'h01);
		mrs(3'h3, 18'h0, 20);
		chk("exit", {act, rdy, 6'h0}, 8'h00);
		repeat (5) @(posedge ck);
		chk("ready", 8'(rdy), 8'h01);
		idle_rd();
		$display("test parallel and exit done");
		test_done();
	end
endmodule : test_dmr_readout
